// ===== mssc_pkg.sv
// Package: register map, field layout and timing constants for soft start
// Assumes a 100 MHz core clock; the design, checker and testbench import it whole.
package mssc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_FILTER_CFG = 8'h0f;
  localparam logic [7:0] ADDR_STARTUP_CFG = 8'h10;
  localparam logic [7:0] ADDR_SOFT_CFG = 8'h11;
  localparam logic [7:0] ADDR_SENSE_CFG = 8'h12;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions
  localparam int GLITCH_SEL_LSB = 0;
  localparam int LIMIT_OFF_BIT = 0;
  localparam int STARTUP_SEL_LSB = 1;
  localparam int DUTY_STEP_LSB = 1;
  localparam int RAMP_STEP_LSB = 4;
  localparam int RAMP_TARGET_LSB = 6;
  localparam int CUTOFF_SEL_LSB = 1;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FILT_TICK_NS = 83;
  localparam int unsigned FILT_TICK_CYC = (FILT_TICK_NS / CLK_PERIOD_NS < 1) ? 1 :
                                          FILT_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned DUTY_TICK_NS = 2_700_000;
  localparam int unsigned DUTY_TICK_CYC_DEF = DUTY_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned RAMP_STEP_MS = 350;
  localparam int unsigned RAMP_STEP_CYC_DEF = RAMP_STEP_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned WAIT_MS = 350;
  localparam int unsigned WAIT_CYC_DEF = WAIT_MS * 1_000_000 / CLK_PERIOD_NS;

  // Current limit levels in permille of the normal limit
  localparam logic [10:0] PERMILLE_FULL = 11'd1000;
  localparam logic [10:0] STARTUP_STEP_PM = 11'd125;

  // Duty accumulator in eighths of 1/512
  localparam int DUTY_ACC_W = 12;
  localparam logic [DUTY_ACC_W-1:0] DUTY_ACC_MAX = 12'hfff;
  localparam logic [6:0] FIXED_DUTY_STEP = 7'd64;

  typedef enum logic [2:0] {ST_IDLE, ST_SOFT, ST_WAIT, ST_RAMP, ST_RUN} phase_e;

endpackage

// ===== motor_soft_start_current_limit.sv
// Soft start duty ramp, startup current limit ramp and comparator glitch filters.
// Assumes comparator inputs arrive asynchronously from pins; commands come
// from the sequencer on clk_i; registers are written by the serial port logic.
// How it works
// - Filter code picks 0/1,4/5,6/7,7/8 filter ticks
// - One field sets both filter lengths
// - Sense cutoff code driven to analog filter
// - Disable bit stops high side cut; soft start duty still freezes on limit comparator
// - Startup duty ramps from zero until limit
// - Limiting enabled: step from duty field
// - Limiting disabled: eight counts per 2.7ms
// - After wait, step limit every 350ms
// - Target clipped at normal limit
// - Forward idling skips startup, normal limit
// - Duty field codes give listed eighths
// - Target adds 0/30/40/50 percent
// - Step is 1/2/5/10 percent
// - Trip cuts high side until next PWM
// - Startup limit 100 down to 12.5 percent
// - Idling duty is speed/max/2
`timescale 1ns/1ps
`default_nettype none
module motor_soft_start_current_limit
  import mssc_pkg::*;
#(
  parameter int unsigned DUTY_TICK_CYC = DUTY_TICK_CYC_DEF,
  parameter int unsigned RAMP_STEP_CYC = RAMP_STEP_CYC_DEF,
  parameter int unsigned WAIT_CYC = WAIT_CYC_DEF
)
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Comparators and PWM timing
  input wire logic oc_limit_cmp_i,
  input wire logic oc_shutdown_cmp_i,
  input wire logic pwm_cycle_start_i,
  // Sequencer
  input wire logic start_cmd_i,
  input wire logic stop_cmd_i,
  input wire logic idling_fwd_i,
  input wire logic sensorless_i,
  input wire logic duty_limit_en_i,
  input wire logic [1:0] top_speed_sel_i,
  input wire logic [15:0] detected_rpm_i,
  // Results
  output logic high_side_off_o,
  output logic shutdown_o,
  output logic [1:0] sense_cutoff_o,
  output logic [8:0] duty_o,
  output logic [9:0] limit_permille_o,
  output logic startup_active_o
);

  function automatic logic [3:0] limit_filt_len(input logic [1:0] code);
    unique case (code)
      2'b00: limit_filt_len = 4'd0;
      2'b01: limit_filt_len = 4'd4;
      2'b10: limit_filt_len = 4'd6;
      2'b11: limit_filt_len = 4'd7;
    endcase
  endfunction

  function automatic logic [6:0] duty_step(input logic [2:0] code);
    unique case (code)
      3'd0: duty_step = 7'd64;
      3'd1: duty_step = 7'd2;
      3'd2: duty_step = 7'd3;
      3'd3: duty_step = 7'd4;
      3'd4: duty_step = 7'd6;
      3'd5: duty_step = 7'd10;
      3'd6: duty_step = 7'd20;
      3'd7: duty_step = 7'd56;
    endcase
  endfunction

  function automatic logic [10:0] target_add(input logic [1:0] code);
    unique case (code)
      2'b00: target_add = 11'd0;
      2'b01: target_add = 11'd300;
      2'b10: target_add = 11'd400;
      2'b11: target_add = 11'd500;
    endcase
  endfunction

  function automatic logic [10:0] ramp_step(input logic [1:0] code);
    unique case (code)
      2'b00: ramp_step = 11'd10;
      2'b01: ramp_step = 11'd20;
      2'b10: ramp_step = 11'd50;
      2'b11: ramp_step = 11'd100;
    endcase
  endfunction

  // Configuration registers
  logic [7:0] filter_cfg;
  logic [7:0] startup_cfg;
  logic [7:0] soft_cfg;
  logic [7:0] sense_cfg;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      filter_cfg <= REG_RESET;
      startup_cfg <= REG_RESET;
      soft_cfg <= REG_RESET;
      sense_cfg <= REG_RESET;
    end
    else if (ce_i && reg_wr_i)
    begin
      if (reg_addr_i == ADDR_FILTER_CFG) filter_cfg <= reg_wdata_i;
      if (reg_addr_i == ADDR_STARTUP_CFG) startup_cfg <= reg_wdata_i;
      if (reg_addr_i == ADDR_SOFT_CFG) soft_cfg <= reg_wdata_i;
      if (reg_addr_i == ADDR_SENSE_CFG) sense_cfg <= reg_wdata_i;
    end
  end

  // Field decode
  wire logic [1:0] glitch_filter_sel = filter_cfg[GLITCH_SEL_LSB +: 2];
  wire logic current_limit_off = startup_cfg[LIMIT_OFF_BIT];
  wire logic [2:0] startup_limit_sel = startup_cfg[STARTUP_SEL_LSB +: 3];
  wire logic [2:0] ramp_duty_step_sel = soft_cfg[DUTY_STEP_LSB +: 3];
  wire logic [1:0] ramp_step_sel = soft_cfg[RAMP_STEP_LSB +: 2];
  wire logic [1:0] ramp_target_sel = soft_cfg[RAMP_TARGET_LSB +: 2];
  wire logic [1:0] sense_cutoff_sel = sense_cfg[CUTOFF_SEL_LSB +: 2];
  wire logic [7:0] read_mux = (reg_addr_i == ADDR_FILTER_CFG) ? filter_cfg :
                              (reg_addr_i == ADDR_STARTUP_CFG) ? startup_cfg :
                              (reg_addr_i == ADDR_SOFT_CFG) ? soft_cfg :
                              (reg_addr_i == ADDR_SENSE_CFG) ? sense_cfg : 8'h00;

  // Filter time base near 12 MHz
  logic [3:0] tick_cnt;
  wire logic filt_tick = (tick_cnt == 4'(FILT_TICK_CYC - 1));

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      tick_cnt <= 4'h0;
    else if (ce_i)
      tick_cnt <= filt_tick ? 4'h0 : tick_cnt + 4'h1;
  end

  // Channel 0 limit comparator, channel 1 shutdown comparator
  wire logic [1:0] cmp_pin = {oc_shutdown_cmp_i, oc_limit_cmp_i};
  logic [1:0] cmp_filt;
  // Shutdown always one tick longer, both from one field
  wire logic [3:0] base_len = limit_filt_len(glitch_filter_sel);
  wire logic [3:0] filt_len [2];
  assign filt_len[0] = base_len;
  assign filt_len[1] = base_len + 4'h1;

  generate
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_filt
      logic sync_a;
      logic sync_b;
      logic [3:0] run;
      always_ff @(posedge clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          sync_a <= 1'b0;
          sync_b <= 1'b0;
          run <= 4'h0;
          cmp_filt[ch] <= 1'b0;
        end
        else if (ce_i)
        begin
          sync_a <= cmp_pin[ch];
          sync_b <= sync_a;
          if (!sync_b)
          begin
            run <= 4'h0;
            cmp_filt[ch] <= 1'b0;
          end
          else
          begin
            if (filt_tick && run < filt_len[ch])
              run <= run + 4'h1;
            cmp_filt[ch] <= (run >= filt_len[ch]);
          end
        end
      end
    end
  endgenerate

  // High side cut per PWM cycle; a trip in the release cycle still wins
  wire logic limit_trip = cmp_filt[0] && !current_limit_off;
  logic high_side_off;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      high_side_off <= 1'b0;
    else if (ce_i)
      high_side_off <= limit_trip || (high_side_off && !pwm_cycle_start_i &&
                                      !current_limit_off);
  end

  // Startup sequencer
  phase_e phase;
  phase_e next_phase;
  logic [31:0] tmr;
  logic [DUTY_ACC_W-1:0] duty_acc;
  logic [10:0] limit_pm;

  wire logic [10:0] startup_pm = STARTUP_STEP_PM * (11'd8 - {8'h00, startup_limit_sel});
  wire logic [10:0] raw_target = startup_pm + target_add(ramp_target_sel);
  wire logic [10:0] ramp_target = (raw_target > PERMILLE_FULL) ? PERMILLE_FULL :
                                  raw_target;
  wire logic [10:0] stepped_pm = limit_pm + ramp_step(ramp_step_sel);
  wire logic ramp_done = (stepped_pm >= ramp_target);

  wire logic [6:0] soft_step = duty_limit_en_i ? duty_step(ramp_duty_step_sel) :
                               FIXED_DUTY_STEP;
  wire logic [DUTY_ACC_W:0] duty_sum = {1'b0, duty_acc} + {6'h00, soft_step};
  wire logic [DUTY_ACC_W-1:0] duty_sat = duty_sum[DUTY_ACC_W] ? DUTY_ACC_MAX :
                                         duty_sum[DUTY_ACC_W-1:0];

  // Speed / max / 2 in eighths of 1/512: rpm >> (1 + select)
  wire logic [15:0] idle_eighths = detected_rpm_i >> (5'd1 + {3'h0, top_speed_sel_i});
  wire logic [DUTY_ACC_W-1:0] idle_duty = (idle_eighths > {4'h0, DUTY_ACC_MAX}) ?
                                          DUTY_ACC_MAX : idle_eighths[DUTY_ACC_W-1:0];

  wire logic duty_tick = (tmr == DUTY_TICK_CYC - 1);
  wire logic wait_done = (tmr == WAIT_CYC - 1);
  wire logic ramp_tick = (tmr == RAMP_STEP_CYC - 1);

  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      ST_IDLE: next_phase = phase;
      ST_SOFT: if (sensorless_i) next_phase = ST_WAIT;
      ST_WAIT: if (wait_done) next_phase = ST_RAMP;
      ST_RAMP: if (ramp_tick && ramp_done) next_phase = ST_RUN;
      ST_RUN: next_phase = phase;
    endcase
    if (start_cmd_i)
      next_phase = idling_fwd_i ? ST_RUN : ST_SOFT;
    if (stop_cmd_i)
      next_phase = ST_IDLE;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      phase <= ST_IDLE;
    else if (ce_i)
      phase <= next_phase;
  end

  // Shared timer: duty steps in soft start, then wait and ramp periods
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      tmr <= 32'h0;
    else if (ce_i)
    begin
      if (next_phase != phase || start_cmd_i)
        tmr <= 32'h0;
      else if (duty_tick && phase == ST_SOFT)
        tmr <= 32'h0;
      else if (ramp_tick && phase == ST_RAMP)
        tmr <= 32'h0;
      else if (phase != ST_IDLE && phase != ST_RUN)
        tmr <= tmr + 32'h1;
    end
  end

  // Duty: starts at zero, or at idle_duty on an idling start, frozen while the limit comparator is active
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      duty_acc <= '0;
    else if (ce_i)
    begin
      if (stop_cmd_i)
        duty_acc <= '0;
      else if (start_cmd_i)
        duty_acc <= idling_fwd_i ? idle_duty : '0;
      else if (phase == ST_SOFT && duty_tick && !cmp_filt[0])
        duty_acc <= duty_sat;
    end
  end

  // Current limit level
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      limit_pm <= PERMILLE_FULL;
    else if (ce_i)
    begin
      if (start_cmd_i)
        limit_pm <= idling_fwd_i ? PERMILLE_FULL : startup_pm;
      else if (phase == ST_SOFT || phase == ST_WAIT)
        limit_pm <= startup_pm;
      else if (phase == ST_RAMP && ramp_tick)
        limit_pm <= ramp_done ? ramp_target : stepped_pm;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= 8'h00;
      high_side_off_o <= 1'b0;
      shutdown_o <= 1'b0;
      sense_cutoff_o <= 2'b00;
      duty_o <= 9'h000;
      limit_permille_o <= 10'h000;
      startup_active_o <= 1'b0;
    end
    else if (ce_i)
    begin
      reg_rdata_o <= read_mux;
      high_side_off_o <= high_side_off;
      shutdown_o <= cmp_filt[1];
      sense_cutoff_o <= sense_cutoff_sel;
      duty_o <= duty_acc[DUTY_ACC_W-1:3];
      limit_permille_o <= limit_pm[9:0];
      startup_active_o <= (phase == ST_SOFT);
    end
  end

endmodule
`default_nettype wire

// ===== mssc_assertions.sv
// Checker: port-level properties of the soft start block.
// Bound to the design below; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mssc_assertions
  import mssc_pkg::*;
(
  // Watched ports
  input wire logic clk_i, resetn_i, ce_i, reg_wr_i, start_cmd_i, stop_cmd_i, idling_fwd_i,
  input wire logic oc_limit_cmp_i, oc_shutdown_cmp_i, pwm_cycle_start_i,
  input wire logic [7:0] reg_addr_i, reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic high_side_off_o, shutdown_o, startup_active_o,
  input wire logic [8:0] duty_o,
  input wire logic [9:0] limit_permille_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [2:0] lim_lo, sd_lo;
  logic mapped, steady;
  assign mapped = reg_addr_i inside {ADDR_FILTER_CFG, ADDR_STARTUP_CFG, ADDR_SOFT_CFG, ADDR_SENSE_CFG};
  // Restart of soft start may drop duty; exclude those cycles
  assign steady = startup_active_o && !start_cmd_i;
  // Cycles since each comparator pin was last high
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      lim_lo <= 3'h7;
      sd_lo <= 3'h7;
    end
    else
    begin
      lim_lo <= oc_limit_cmp_i ? 3'h0 : lim_lo + {2'h0, lim_lo != 3'h7};
      sd_lo <= oc_shutdown_cmp_i ? 3'h0 : sd_lo + {2'h0, sd_lo != 3'h7};
    end
  trip_cause_a: assert property ($rose(high_side_off_o) |-> lim_lo != 3'h7)
    else $error("high side cut without comparator");
  trip_hold_a: assert property ($fell(high_side_off_o) |-> $past(pwm_cycle_start_i) ||
    $past(pwm_cycle_start_i, 2) || $past(reg_wr_i, 2) || $past(reg_wr_i, 3))
    else $error("high side released outside pwm start");
  sd_cause_a: assert property ($rose(shutdown_o) |-> sd_lo != 3'h7)
    else $error("shutdown without comparator");
  sd_release_a: assert property (!oc_shutdown_cmp_i [*6] |-> !shutdown_o)
    else $error("shutdown held after pin low");
  duty_rise_a: assert property (steady ##1 steady ##1 steady |-> duty_o >= $past(duty_o))
    else $error("soft start duty fell");
  duty_rate_a: assert property (steady ##1 steady |-> {1'b0, duty_o} <= {1'b0, $past(duty_o)} + 10'd8)
    else $error("soft start duty step too big");
  soft_start_a: assert property (ce_i && start_cmd_i && !idling_fwd_i && !stop_cmd_i
    |-> ##2 startup_active_o && duty_o == 9'h0)
    else $error("soft start not from zero");
  idle_start_a: assert property (ce_i && start_cmd_i && idling_fwd_i && !stop_cmd_i
    |-> ##2 !startup_active_o && limit_permille_o == 10'd1000)
    else $error("idling start not at normal limit");
  limit_cap_a: assert property (limit_permille_o <= 10'd1000)
    else $error("limit above normal");
  reg_back_a: assert property (ce_i && reg_wr_i && mapped ##1 ce_i && !reg_wr_i && $stable(reg_addr_i)
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("register readback wrong");
  unmapped_a: assert property (ce_i && !mapped |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  cover property ($rose(high_side_off_o));
  cover property ($rose(shutdown_o));
  cover property (start_cmd_i && idling_fwd_i);
endmodule
bind motor_soft_start_current_limit mssc_assertions chk_u (.clk_i, .resetn_i, .ce_i, .reg_wr_i,
  .start_cmd_i, .stop_cmd_i, .idling_fwd_i, .oc_limit_cmp_i, .oc_shutdown_cmp_i,
  .pwm_cycle_start_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .high_side_off_o, .shutdown_o,
  .startup_active_o, .duty_o, .limit_permille_o);
`default_nettype wire

// ===== bridge_model.sv
// Bridge model: FET bridge and shunt seen as a comparator level and PWM frame.
// Shunt current follows duty; the bench sets the trip level.
`timescale 1ns/1ps
`default_nettype none
module bridge_model (
  // Clock and drive
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [8:0] duty_i,
  input wire logic [8:0] trip_i,
  // Comparator and frame
  output logic limit_cmp_o,
  output logic pwm_start_o
);
  logic [5:0] pwm_cnt;
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      pwm_cnt <= 6'h0;
    else
      pwm_cnt <= pwm_cnt + 6'h1;
  // Level stays over while duty is high, so a trip persists across frames
  assign limit_cmp_o = duty_i >= trip_i;
  assign pwm_start_o = pwm_cnt == 6'h00;
endmodule
`default_nettype wire

// ===== testbench.sv
// Testbench: register port tasks and command sequences with expected values.
// Uses shortened tick parameters; bridge model supplies comparator and PWM.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mssc_pkg::*;
  logic clk_i = 0, resetn_i = 0, reg_wr_i = 0, lim_pulse = 0, sd_cmp = 0, stop_cmd = 0;
  logic start_cmd = 0, idling = 0, sensorless = 0, dlim_en = 0, seen_hs = 0, seen_sd = 0;
  logic pwm, model_cmp, hs_off, sd, active;
  logic ce = 1;
  logic [1:0] top_sel = 2'h0, cutoff;
  logic [15:0] rpm = 16'h0;
  logic [7:0] addr = 8'h0, wdata = 8'h0, rdata;
  logic [8:0] trip = 9'h1ff, duty, d0;
  logic [9:0] lim;
  logic [9:0] steps [8] = '{10'd64, 10'd2, 10'd3, 10'd4, 10'd6, 10'd10, 10'd20, 10'd56};
  int flen [4] = '{0, 4, 6, 7};
  // Startup code, target code, step code, final limit, limit after the first step
  int rt [4][5] = '{'{4, 1, 3, 800, 600}, '{0, 3, 0, 1000, 1000},
    '{7, 3, 0, 625, 135}, '{6, 2, 2, 650, 300}};
  int fail_count = 0, num_checks = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  motor_soft_start_current_limit #(.DUTY_TICK_CYC(20), .RAMP_STEP_CYC(30), .WAIT_CYC(10)) dut_u (
    .clk_i, .resetn_i, .ce_i(ce), .reg_wr_i, .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .oc_limit_cmp_i(model_cmp | lim_pulse), .oc_shutdown_cmp_i(sd_cmp),
    .pwm_cycle_start_i(pwm), .start_cmd_i(start_cmd), .stop_cmd_i(stop_cmd), .idling_fwd_i(idling),
    .sensorless_i(sensorless), .duty_limit_en_i(dlim_en), .top_speed_sel_i(top_sel),
    .detected_rpm_i(rpm), .high_side_off_o(hs_off), .shutdown_o(sd), .sense_cutoff_o(cutoff),
    .duty_o(duty), .limit_permille_o(lim), .startup_active_o(active));
  bridge_model model_u (.clk_i, .resetn_i, .duty_i(duty), .trip_i(trip),
    .limit_cmp_o(model_cmp), .pwm_start_o(pwm));
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    reg_wr_i <= 1;
    @(posedge clk_i);
    reg_wr_i <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    repeat (2) @(posedge clk_i);
    #1 cmp(10'(rdata), 10'(exp));
  endtask
  task automatic go(input logic idl);
    @(posedge clk_i);
    idling <= idl;
    start_cmd <= 1;
    @(posedge clk_i);
    start_cmd <= 0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic pulse(input int n);
    @(posedge clk_i);
    seen_hs <= 0;
    seen_sd <= 0;
    lim_pulse <= 1;
    sd_cmp <= 1;
    repeat (n) @(posedge clk_i);
    lim_pulse <= 0;
    sd_cmp <= 0;
    repeat (80) @(posedge clk_i);
    #1;
  endtask
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (hs_off) seen_hs <= 1;
    if (sd) seen_sd <= 1;
    if (cyc == 30000)
    begin
      fail_count++;
      summarize();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1;
    for (int a = 15; a < 20; a++)
    begin
      rd(8'(a), 8'h00);
      wr(8'(a), 8'(a) ^ 8'ha5);
      rd(8'(a), a < 19 ? 8'(a) ^ 8'ha5 : 8'h00);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_SENSE_CFG, 8'(c << 1));
      repeat (2) @(posedge clk_i);
      #1 cmp(10'(cutoff), 10'(c));
    end
    wr(ADDR_SOFT_CFG, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      wr(ADDR_STARTUP_CFG, 8'(c << 1));
      go(0);
      cmp(lim, 10'(125 * (8 - c)));
      cmp(10'(active), 10'h1);
    end
    for (int c = 0; c < 9; c++)
    begin
      wr(ADDR_SOFT_CFG, 8'((c == 8 ? 7 : c) << 1));
      dlim_en <= c < 8;
      go(0);
      d0 = duty;
      repeat (160) @(posedge clk_i);
      #1 cmp(10'(duty - d0), c < 8 ? steps[c] : 10'd64);
    end
    // Unfiltered trip, so duty freezes at the first step over the level
    wr(ADDR_FILTER_CFG, 8'h00);
    @(posedge clk_i);
    trip <= 9'd40;
    go(0);
    repeat (300) @(posedge clk_i);
    #1 d0 = duty;
    repeat (100) @(posedge clk_i);
    #1 cmp(10'(duty), 10'(d0));
    cmp(10'(d0 >= 9'd40 && d0 < 9'd48), 10'h1);
    cmp(10'(hs_off), 10'h1);
    wr(ADDR_STARTUP_CFG, 8'h01);
    repeat (4) @(posedge clk_i);
    #1 cmp(10'(hs_off), 10'h0);
    @(posedge clk_i);
    trip <= 9'h1ff;
    stop_cmd <= 1;
    @(posedge clk_i);
    stop_cmd <= 0;
    wr(ADDR_STARTUP_CFG, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_FILTER_CFG, 8'(c));
      // 8L+1 synced edges hold exactly L ticks: limit trips, shutdown never does
      pulse(8 * flen[c] + 1);
      cmp(10'(seen_hs), 10'h1);
      cmp(10'(seen_sd), 10'h0);
      pulse(8 * flen[c] + 16);
      cmp(10'(seen_sd), 10'h1);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_STARTUP_CFG, 8'(rt[i][0] << 1));
      wr(ADDR_SOFT_CFG, 8'((rt[i][1] << 6) | (rt[i][2] << 4)));
      go(0);
      @(posedge clk_i);
      sensorless <= 1;
      @(posedge clk_i);
      sensorless <= 0;
      repeat (60) @(posedge clk_i);
      #1 cmp(lim, 10'(rt[i][4]));
      repeat (1700) @(posedge clk_i);
      #1 cmp(lim, 10'(rt[i][3]));
      go(0);
      cmp(lim, 10'(125 * (8 - rt[i][0])));
    end
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk_i);
      top_sel <= 2'(s);
      rpm <= s == 3 ? 16'hffff : 16'd3000;
      go(1);
      cmp(lim, 10'd1000);
      cmp(10'(active), 10'h0);
      cmp(10'(duty), s == 3 ? 10'd511 : 10'(3000 >> (4 + s)));
    end
    // Clock enable low must freeze the soft start duty and its timer
    go(0);
    @(posedge clk_i);
    ce <= 0;
    repeat (100) @(posedge clk_i);
    #1 cmp(10'(duty), 10'h0);
    @(posedge clk_i);
    ce <= 1;
    repeat (30) @(posedge clk_i);
    #1 cmp(10'(duty), 10'd8);
    summarize();
  end
endmodule
`default_nettype wire
